// ### verilog/drcv_pkg.sv
// Shared constants, register layouts and carrier types of the receive channel
package drcv_pkg;

  // Datapath widths and limits
  localparam int MANT_W = 16;
  localparam int EXP_W = 3;
  localparam int PHASE_W = 32;
  localparam int COEF_W = 20;
  localparam int FIR_TAPS = 256;
  localparam int FIR_TAP_W = 8;
  localparam int FIR_ACC_W = 44;
  localparam int OUT_W = 16;
  localparam int MIX_W = 17;
  localparam int COMB1_ORDER = 2;
  localparam int COMB2_ORDER = 5;
  localparam int COMB1_ACC_W = 25;
  localparam int COMB2_ACC_W = 41;
  localparam int CTL_FRAME_W = 40;

  // Register byte offsets on APB
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_NCO_FREQ = 8'h04;
  localparam logic [7:0] REG_NCO_PHASE = 8'h08;
  localparam logic [7:0] REG_DECIM = 8'h0C;
  localparam logic [7:0] REG_SCALE = 8'h10;
  localparam logic [7:0] REG_COEF_ADDR = 8'h14;
  localparam logic [7:0] REG_COEF_DATA = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  // Input modes
  typedef enum logic [1:0] {MODE_REAL, MODE_COMPLEX, MODE_DIVERSITY, MODE_RSVD} drcv_mode_t;

  // Control word; the two go bits are write-only pulses
  typedef struct packed {
    logic [23:0] rsvd;
    logic dec_sync_go;
    logic nco_sync_go;
    logic sync_master;
    logic comb_bypass;
    logic amp_dither;
    logic phase_dither;
    drcv_mode_t mode;
  } drcv_ctrl_t;

  // Decimation factors and tap count, each stored as value minus one
  typedef struct packed {
    logic [9:0] rsvd;
    logic [7:0] taps_m1;
    logic [4:0] fir_m1;
    logic [4:0] comb2_m1;
    logic [3:0] comb1_m1;
  } drcv_decim_t;

  // Right shifts that bring each stage back to sixteen bits
  typedef struct packed {
    logic [16:0] rsvd;
    logic [4:0] fir_shift;
    logic [5:0] comb2_shift;
    logic [3:0] comb1_shift;
  } drcv_scale_t;

  // Reset values
  localparam drcv_ctrl_t CTRL_RST = '0;
  localparam drcv_decim_t DECIM_RST = '{rsvd: '0, taps_m1: 8'h00, fir_m1: 5'h00,
                                        comb2_m1: 5'h00, comb1_m1: 4'h1};
  localparam drcv_scale_t SCALE_RST = '{rsvd: '0, fir_shift: 5'h13, comb2_shift: 6'h00,
                                        comb1_shift: 4'h2};
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  // One ADC sample as captured from the pins
  typedef struct packed {
    logic channel_select_in;
    logic [EXP_W-1:0] sample_exponent_in;
    logic [MANT_W-1:0] sample_mantissa_in;
  } drcv_sample_t;

  // One baseband output word with its markers
  typedef struct packed {
    logic valid;
    logic iq;
    logic ch;
    logic [OUT_W-1:0] word;
  } drcv_bb_t;

  // Quarter-wave sine, 16 steps plus the peak, full scale 32767
  localparam logic [15:0] QSIN [17] = '{16'h0000, 16'h0C8C, 16'h18F9, 16'h2528, 16'h30FC,
    16'h3C57, 16'h471D, 16'h5134, 16'h5A82, 16'h62F2, 16'h6A6E, 16'h70E3, 16'h7642,
    16'h7A7D, 16'h7D8A, 16'h7F62, 16'h7FFF};

endpackage

// ### verilog/drcv_mem.sv
// Simple dual-port memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module drcv_mem #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW) || WIDTH < 1)
  begin : g_bad_size
    $error("drcv_mem: depth does not fit the address width");
  end

  // No reset, so the array maps onto block RAM
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ### verilog/drcv_comb.sv
// Decimating integrator-comb filter of configurable order
`timescale 1ns/10ps
`default_nettype none
module drcv_comb #(
  parameter int ORDER = 2,
  parameter int IN_W = 17,
  parameter int ACC_W = 25,
  parameter int FACT_W = 4,
  parameter int SH_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire logic clear,
  input wire logic [FACT_W-1:0] factor_m1,
  input wire logic [SH_W-1:0] shift,
  // Sample stream in
  input wire logic in_valid,
  input wire logic [IN_W-1:0] in_data,
  // Decimated stream out
  output logic out_valid,
  output logic [15:0] out_data
);
  typedef struct packed {
    logic [ORDER-1:0][ACC_W-1:0] integ;
    logic [ORDER-1:0][ACC_W-1:0] dly;
    logic [FACT_W-1:0] cnt;
    logic valid;
    logic [15:0] data;
  } drcv_comb_state_t;

  drcv_comb_state_t r, n;

  if (ORDER < 1 || ACC_W < IN_W || ACC_W < 16)
  begin : g_bad_cfg
    $error("drcv_comb: accumulator narrower than its input");
  end

  // Integrators run at the input rate, combs only on the kept sample;
  // modulo arithmetic makes integrator wrap harmless
  always_comb
  begin
    logic [ACC_W-1:0] s;
    logic [ACC_W-1:0] d;
    s = '0;
    d = '0;
    n = r;
    n.valid = 1'b0;
    if (clear)
    begin
      n.integ = '0;
      n.dly = '0;
      n.cnt = '0;
    end
    else if (in_valid)
    begin
      s = ACC_W'($signed(in_data));
      for (int k = 0; k < ORDER; k++)
      begin
        n.integ[k] = r.integ[k] + s;
        s = n.integ[k];
      end
      if (r.cnt == factor_m1)
      begin
        n.cnt = '0;
        d = s;
        for (int k = 0; k < ORDER; k++)
        begin
          n.dly[k] = d;
          d = d - r.dly[k];
        end
        n.data = 16'($signed(d) >>> shift);
        n.valid = 1'b1;
      end
      else
      begin
        n.cnt = r.cnt + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign out_valid = r.valid;
  assign out_data = r.data;
endmodule
`default_nettype wire

// ### verilog/drcv_top.sv
// Decimating receive channel: mixer, two comb decimators, RAM-coefficient FIR
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module drcv_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ADC sample port
  input wire drcv_pkg::drcv_sample_t sample_in,
  input wire logic sample_strobe_in,
  // Serial control port
  input wire logic ctl_sclk_in,
  input wire logic ctl_sdi_in,
  input wire logic ctl_cs_n_in,
  // Baseband output
  input wire logic serial_out_select_in,
  output drcv_pkg::drcv_bb_t bb_out,
  output logic ser_data_out,
  output logic ser_frame_out,
  // Synchronisation pins, split into in, out and active-low enable
  input wire logic sync_nco_in,
  output logic sync_nco_out,
  output logic sync_nco_oe_n,
  input wire logic sync_dec_in,
  output logic sync_dec_out,
  output logic sync_dec_oe_n
);
  typedef enum {F_IDLE, F_RUN, F_DRAIN, F_OUT_I, F_OUT_Q} drcv_fir_st_t;

  typedef struct packed {
    drcv_pkg::drcv_sample_t smp1;
    drcv_pkg::drcv_sample_t smp2;
    logic stb1;
    logic stb2;
    logic ser1;
    logic ser2;
    logic [1:0] sn1;
    logic [1:0] sn2;
    logic [1:0] sn3;
    logic [2:0] ct1;
    logic [2:0] ct2;
    logic [2:0] ct3;
    logic [drcv_pkg::CTL_FRAME_W-1:0] ct_shift;
    logic [5:0] ct_cnt;
    logic ct_pend;
    drcv_pkg::drcv_ctrl_t ctrl;
    drcv_pkg::drcv_decim_t decim;
    drcv_pkg::drcv_scale_t scale;
    logic [31:0] freq;
    logic [31:0] poff;
    logic [7:0] coef_addr;
    logic [31:0] acc;
    logic [15:0] lfsr;
    logic [15:0] held_i;
    logic mix_v;
    logic mix_ch;
    logic [16:0] mix_i;
    logic [16:0] mix_q;
    logic comb_clear;
    logic dwe;
    logic [8:0] dwa;
    logic [31:0] dwd;
    logic [1:0][7:0] wptr;
    logic [1:0][4:0] fcnt;
    logic [1:0] pend;
    logic cwe;
    logic [7:0] cwa;
    logic [19:0] cwd;
    drcv_fir_st_t fst;
    logic fch;
    logic [7:0] tap;
    logic [7:0] base;
    logic [8:0] rd_da;
    logic [7:0] rd_ca;
    logic lag1;
    logic lag2;
    logic [43:0] acc_i;
    logic [43:0] acc_q;
    drcv_pkg::drcv_bb_t bb;
    logic [15:0] shift;
    logic [3:0] sbits;
    logic sdata;
    logic sframe;
    logic [1:0] sync_out;
    logic [1:0] sync_oe_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] word_cnt;
  } drcv_state_t;

  drcv_state_t r, n;

  // Lane k carries channel k[1], component k[0] (0 = I)
  logic [3:0] c1_v;
  logic [3:0][15:0] c1_d;
  logic [3:0] c2_v;
  logic [3:0][15:0] c2_d;
  logic [19:0] coef_rd;
  logic [31:0] dat_rd;

  function automatic logic signed [16:0] drcv_sin(input logic [5:0] p);
    logic [4:0] k;
    logic signed [16:0] m;
    k = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
    m = $signed({1'b0, drcv_pkg::QSIN[k]});
    return p[5] ? -m : m;
  endfunction

  // Both comb stages per lane, in fixed cascade behind the mixer
  for (genvar k = 0; k < 4; k++)
  begin : g_lane
    drcv_comb #(
      .ORDER(drcv_pkg::COMB1_ORDER), .IN_W(drcv_pkg::MIX_W),
      .ACC_W(drcv_pkg::COMB1_ACC_W), .FACT_W(4), .SH_W(4)
    ) u_comb1 (
      .clk(pclk), .rst_n(presetn), .clear(r.comb_clear),
      .factor_m1(r.decim.comb1_m1), .shift(r.scale.comb1_shift),
      .in_valid(r.mix_v && (r.mix_ch == 1'(k / 2)) && !r.ctrl.comb_bypass),
      .in_data((k % 2 == 1) ? r.mix_q : r.mix_i),
      .out_valid(c1_v[k]), .out_data(c1_d[k])
    );
    drcv_comb #(
      .ORDER(drcv_pkg::COMB2_ORDER), .IN_W(16),
      .ACC_W(drcv_pkg::COMB2_ACC_W), .FACT_W(5), .SH_W(6)
    ) u_comb2 (
      .clk(pclk), .rst_n(presetn), .clear(r.comb_clear),
      .factor_m1(r.decim.comb2_m1), .shift(r.scale.comb2_shift),
      .in_valid(c1_v[k]), .in_data(c1_d[k]),
      .out_valid(c2_v[k]), .out_data(c2_d[k])
    );
  end

  // FIR coefficients and per-channel sample history
  drcv_mem #(.WIDTH(drcv_pkg::COEF_W), .DEPTH(drcv_pkg::FIR_TAPS), .AW(8)) u_coef (
    .clk(pclk), .wr_en(r.cwe), .wr_addr(r.cwa), .wr_data(r.cwd),
    .rd_addr(r.rd_ca), .rd_data(coef_rd)
  );
  drcv_mem #(.WIDTH(32), .DEPTH(2 * drcv_pkg::FIR_TAPS), .AW(9)) u_hist (
    .clk(pclk), .wr_en(r.dwe), .wr_addr(r.dwa), .wr_data(r.dwd),
    .rd_addr(r.rd_da), .rd_data(dat_rd)
  );

  logic signed [15:0] x;
  logic signed [16:0] cv;
  logic signed [16:0] sv;
  logic signed [33:0] pi_w;
  logic signed [33:0] pq_w;
  logic [31:0] ph;
  logic adv;
  logic mix;
  logic nco_evt;
  logic dec_evt;
  logic wen;
  logic [7:0] wa;
  logic [31:0] wd;
  logic fv;
  logic [15:0] fi;
  logic [15:0] fq;
  logic signed [35:0] mi;
  logic signed [35:0] mq;
  logic [15:0] w;

  always_comb
  begin
    x = '0;
    cv = '0;
    sv = '0;
    pi_w = '0;
    pq_w = '0;
    ph = '0;
    adv = 1'b0;
    mix = 1'b0;
    wen = 1'b0;
    wa = '0;
    wd = '0;
    fv = 1'b0;
    fi = '0;
    fq = '0;
    mi = '0;
    mq = '0;
    w = '0;
    n = r;
    // Sample pins pass two flops, sync and control pins three; edge detects also read the third
    n.smp1 = sample_in;
    n.smp2 = r.smp1;
    n.stb1 = sample_strobe_in;
    n.stb2 = r.stb1;
    n.ser1 = serial_out_select_in;
    n.ser2 = r.ser1;
    n.sn1 = {sync_dec_in, sync_nco_in};
    n.sn2 = r.sn1;
    n.sn3 = r.sn2;
    n.ct1 = {ctl_cs_n_in, ctl_sdi_in, ctl_sclk_in};
    n.ct2 = r.ct1;
    n.ct3 = r.ct2;
    n.ctrl.nco_sync_go = 1'b0;
    n.ctrl.dec_sync_go = 1'b0;
    n.cwe = 1'b0;
    n.dwe = 1'b0;
    n.mix_v = 1'b0;
    n.comb_clear = 1'b0;
    n.lag1 = 1'b0;
    n.lag2 = r.lag1;
    n.bb.valid = 1'b0;
    n.sframe = 1'b0;

    // Master drives its pulse out; followers react to a rising pin
    nco_evt = r.ctrl.sync_master ? r.ctrl.nco_sync_go : (r.sn2[0] & ~r.sn3[0]);
    dec_evt = r.ctrl.sync_master ? r.ctrl.dec_sync_go : (r.sn2[1] & ~r.sn3[1]);
    n.sync_out = {r.ctrl.dec_sync_go, r.ctrl.nco_sync_go};
    n.sync_oe_n = {2{~r.ctrl.sync_master}};

    // Oscillator phase with offset and optional sub-step dither
    ph = r.acc + r.poff;
    if (r.ctrl.phase_dither)
    begin
      ph = ph + {6'h00, r.lfsr[7:0], 18'h00000};
    end
    cv = drcv_sin(ph[31:26] + 6'h10);
    sv = drcv_sin(ph[31:26]);
    if (r.ctrl.amp_dither)
    begin
      cv = cv + $signed({16'h0000, r.lfsr[8]});
      sv = sv + $signed({16'h0000, r.lfsr[9]});
    end
    x = $signed(r.smp2.sample_mantissa_in) >>> r.smp2.sample_exponent_in;

    // Mixer; in two-sample modes the phase steps once per select-high sample
    if (r.stb2)
    begin
      case (r.ctrl.mode)
        drcv_pkg::MODE_COMPLEX:
        begin
          if (!r.smp2.channel_select_in)
          begin
            n.held_i = x;
          end
          else
          begin
            pi_w = $signed(r.held_i) * cv + x * sv;
            pq_w = x * cv - $signed(r.held_i) * sv;
            mix = 1'b1;
            adv = 1'b1;
            n.mix_ch = 1'b0;
          end
        end
        drcv_pkg::MODE_DIVERSITY:
        begin
          pi_w = x * cv;
          pq_w = -(x * sv);
          mix = 1'b1;
          adv = r.smp2.channel_select_in;
          n.mix_ch = r.smp2.channel_select_in;
        end
        default:
        begin
          pi_w = x * cv;
          pq_w = -(x * sv);
          mix = 1'b1;
          adv = 1'b1;
          n.mix_ch = 1'b0;
        end
      endcase
    end
    if (mix)
    begin
      n.mix_v = 1'b1;
      n.mix_i = pi_w[31:15];
      n.mix_q = pq_w[31:15];
    end
    if (adv)
    begin
      n.acc = r.acc + r.freq;
      n.lfsr = {r.lfsr[14:0], r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10]};
    end
    if (nco_evt)
    begin
      n.acc = '0;
    end

    // Serial control frame: 8-bit address then 32-bit data, MSB first
    if (r.ct2[2])
    begin
      n.ct_cnt = '0;
    end
    else if (r.ct2[0] && !r.ct3[0])
    begin
      n.ct_shift = {r.ct_shift[drcv_pkg::CTL_FRAME_W-2:0], r.ct2[1]};
      n.ct_cnt = (r.ct_cnt == 6'h3F) ? r.ct_cnt : r.ct_cnt + 6'h01;
    end

    // APB answers with no wait state; the read is formed in the setup cycle
    n.pready = psel & ~penable;
    if (psel && !penable)
    begin
      n.pslverr = 1'b0;
      case (paddr)
        drcv_pkg::REG_CTRL: n.prdata = r.ctrl;
        drcv_pkg::REG_NCO_FREQ: n.prdata = r.freq;
        drcv_pkg::REG_NCO_PHASE: n.prdata = r.poff;
        drcv_pkg::REG_DECIM: n.prdata = r.decim;
        drcv_pkg::REG_SCALE: n.prdata = r.scale;
        drcv_pkg::REG_COEF_ADDR: n.prdata = {24'h000000, r.coef_addr};
        drcv_pkg::REG_COEF_DATA: n.prdata = 32'h00000000;
        drcv_pkg::REG_STATUS:
          n.prdata = {r.word_cnt, 12'h000, r.ser2, r.pend, r.fst != F_IDLE};
        default:
        begin
          n.prdata = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end

    // One write path shared by both ports; APB first, serial waits a cycle
    if (psel && penable && r.pready && pwrite && !r.pslverr)
    begin
      wen = 1'b1;
      wa = paddr;
      wd = pwdata;
    end
    else if (r.ct_pend)
    begin
      wen = 1'b1;
      wa = r.ct_shift[39:32];
      wd = r.ct_shift[31:0];
      n.ct_pend = 1'b0;
    end
    if (r.ct2[2] && !r.ct3[2] && r.ct_cnt == 6'(drcv_pkg::CTL_FRAME_W))
    begin
      n.ct_pend = 1'b1;
    end
    if (wen)
    begin
      case (wa)
        drcv_pkg::REG_CTRL: n.ctrl = drcv_pkg::drcv_ctrl_t'({24'h000000, wd[7:0]});
        drcv_pkg::REG_NCO_FREQ: n.freq = wd;
        drcv_pkg::REG_NCO_PHASE: n.poff = wd;
        drcv_pkg::REG_DECIM: n.decim = drcv_pkg::drcv_decim_t'({10'h000, wd[21:0]});
        drcv_pkg::REG_SCALE: n.scale = drcv_pkg::drcv_scale_t'({17'h00000, wd[14:0]});
        drcv_pkg::REG_COEF_ADDR: n.coef_addr = wd[7:0];
        drcv_pkg::REG_COEF_DATA:
        begin
          n.cwe = 1'b1;
          n.cwa = r.coef_addr;
          n.cwd = wd[19:0];
          n.coef_addr = r.coef_addr + 8'h01;
        end
        default: n.cwe = 1'b0;
      endcase
    end

    // FIR engine: start a waiting channel, channel 0 first whenever both wait
    case (r.fst)
      F_IDLE:
      begin
        if (r.pend != 2'b00)
        begin
          n.fch = ~r.pend[0];
          n.pend[~r.pend[0]] = 1'b0;
          n.base = r.wptr[~r.pend[0]];
          n.tap = '0;
          n.acc_i = '0;
          n.acc_q = '0;
          n.fst = F_RUN;
        end
      end
      F_RUN:
      begin
        n.rd_da = {r.fch, r.base - 8'h01 - r.tap};
        n.rd_ca = r.tap;
        n.lag1 = 1'b1;
        n.tap = r.tap + 8'h01;
        if (r.tap == r.decim.taps_m1)
        begin
          n.fst = F_DRAIN;
        end
      end
      F_DRAIN:
      begin
        if (!r.lag1 && !r.lag2)
        begin
          n.fst = F_OUT_I;
        end
      end
      F_OUT_I, F_OUT_Q:
      begin
        w = 16'($signed(r.fst == F_OUT_I ? r.acc_i : r.acc_q) >>> r.scale.fir_shift);
        if (!r.ser2)
        begin
          n.bb = '{valid: 1'b1, iq: r.fst == F_OUT_Q, ch: r.fch, word: w};
          n.word_cnt = r.word_cnt + 16'h0001;
          n.fst = (r.fst == F_OUT_I) ? F_OUT_Q : F_IDLE;
        end
        else if (r.sbits == 4'h0)
        begin
          n.sdata = w[15];
          n.shift = {w[14:0], 1'b0};
          n.sbits = 4'hF;
          n.sframe = 1'b1;
          n.word_cnt = r.word_cnt + 16'h0001;
          n.fst = (r.fst == F_OUT_I) ? F_OUT_Q : F_IDLE;
        end
      end
      default: n.fst = F_IDLE;
    endcase
    if (r.lag2)
    begin
      mi = $signed(coef_rd) * $signed(dat_rd[15:0]);
      mq = $signed(coef_rd) * $signed(dat_rd[31:16]);
      n.acc_i = r.acc_i + 44'(mi);
      n.acc_q = r.acc_q + 44'(mq);
    end

    // Serial output shifts one bit per clock after the framed first bit
    if (r.sbits != 4'h0 && !n.sframe)
    begin
      n.sdata = r.shift[15];
      n.shift = {r.shift[14:0], 1'b0};
      n.sbits = r.sbits - 4'h1;
    end

    // FIR input per channel, from the comb cascade or straight from the mixer
    for (int c = 0; c < 2; c++)
    begin
      if (r.ctrl.comb_bypass)
      begin
        fv = r.mix_v && (r.mix_ch == c[0]);
        fi = r.mix_i[16:1];
        fq = r.mix_q[16:1];
      end
      else
      begin
        fv = c2_v[2 * c];
        fi = c2_d[2 * c];
        fq = c2_d[2 * c + 1];
      end
      if (fv)
      begin
        n.dwe = 1'b1;
        n.dwa = {c[0], r.wptr[c]};
        n.dwd = {fq, fi};
        n.wptr[c] = r.wptr[c] + 8'h01;
        if (r.fcnt[c] == r.decim.fir_m1)
        begin
          n.fcnt[c] = '0;
          n.pend[c] = 1'b1;
        end
        else
        begin
          n.fcnt[c] = r.fcnt[c] + 5'h01;
        end
      end
    end

    // Timing sync realigns every decimator and drops waiting outputs
    if (dec_evt)
    begin
      n.comb_clear = 1'b1;
      n.fcnt = '0;
      n.pend = 2'b00;
    end
  end

  // State register; reset holds every stage idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.ctrl <= drcv_pkg::CTRL_RST;
      r.decim <= drcv_pkg::DECIM_RST;
      r.scale <= drcv_pkg::SCALE_RST;
      r.lfsr <= drcv_pkg::LFSR_SEED;
      r.fst <= F_IDLE;
      r.sync_oe_n <= 2'b11;
    end
    else
    begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign bb_out = r.bb;
  assign ser_data_out = r.sdata;
  assign ser_frame_out = r.sframe;
  assign sync_nco_out = r.sync_out[0];
  assign sync_dec_out = r.sync_out[1];
  assign sync_nco_oe_n = r.sync_oe_n[0];
  assign sync_dec_oe_n = r.sync_oe_n[1];
endmodule
`default_nettype wire

// ### verif/drcv_top_properties.sv
// Port assertions for the receive channel top
`timescale 1ns/10ps
`default_nettype none
module drcv_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire drcv_pkg::drcv_bb_t bb_out,
  input wire logic sync_dec_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Wait-free slave: one access cycle only
  rdy_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("ready late");
  rdy_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held");
  // Unmapped place refused and reads zero
  bad_addr_a: assert property (pready && paddr > 8'h1C |-> pslverr)
    else $error("no slverr");
  bad_read_a: assert property (pready && pslverr && !pwrite |-> prdata == '0)
    else $error("refused read not 0");
  // Q follows I at once on the same channel, then the strobe drops
  iq_pair_a: assert property (bb_out.valid && !bb_out.iq |=>
    bb_out.valid && bb_out.iq && bb_out.ch == $past(bb_out.ch)) else $error("no Q after I");
  q_end_a: assert property (bb_out.valid && bb_out.iq |=> !bb_out.valid)
    else $error("strobe too long");
  word_hold_a: assert property (!bb_out.valid |-> $stable(bb_out.word))
    else $error("word moved");
  // Everything idle as reset lets go
  rst_idle_a: assert property ($rose(presetn) |-> bb_out == '0 && sync_dec_oe_n)
    else $error("not idle after reset");
endmodule
bind drcv_top drcv_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .bb_out(bb_out), .sync_dec_oe_n(sync_dec_oe_n));
`default_nettype wire

// ### verif/drcv_adc_model.sv
// Behavioural ADC: strobe every other clock, channel select alternating
`timescale 1ns/10ps
`default_nettype none
module drcv_adc_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Run control
  input wire logic en,
  // Sample port
  output drcv_pkg::drcv_sample_t smp,
  output logic stb
);
  // Off-strobe the exponent and mantissa lines invert, so stale data never looks valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stb <= 1'b0;
      smp <= {1'b1, 3'h0, 16'h0000};
    end
    else if (en && !stb)
    begin
      stb <= 1'b1;
      smp <= {~smp.channel_select_in, 3'h0, 16'h4000}; // A then B
    end
    else
    begin
      stb <= 1'b0;
      smp <= {smp.channel_select_in, ~smp.sample_exponent_in, ~smp.sample_mantissa_in};
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_drcv_top.sv
// Self-checking bench for the receive channel
`timescale 1ns/10ps
`default_nettype none
module tb_drcv_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sel = 0, en = 0;
  logic csck = 0, csdi = 0, ccs_n = 1;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, sdo, sfr, stb, sno, snoe;
  drcv_pkg::drcv_sample_t smp;
  drcv_pkg::drcv_bb_t bb;
  int errors = 0, n_checks = 0, cyc = 0, n0 = 0, n1 = 0, nf = 0;
  always #12.5 pclk = ~pclk;
  // Sync inputs idle
  drcv_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_in(smp), .sample_strobe_in(stb), .ctl_sclk_in(csck),
    .ctl_sdi_in(csdi), .ctl_cs_n_in(ccs_n), .serial_out_select_in(sel), .bb_out(bb),
    .ser_data_out(sdo), .ser_frame_out(sfr), .sync_nco_in(1'b0), .sync_nco_out(sno),
    .sync_nco_oe_n(snoe), .sync_dec_in(1'b0), .sync_dec_out(), .sync_dec_oe_n());
  drcv_adc_model adc (.pclk(pclk), .presetn(presetn), .en(en), .smp(smp), .stb(stb));
  // Tally I words per channel and serial frames; cut a hang short
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    n0 <= n0 + int'(bb.valid === 1'b1 && bb.iq === 1'b0 && bb.ch === 1'b0);
    n1 <= n1 + int'(bb.valid === 1'b1 && bb.iq === 1'b0 && bb.ch === 1'b1);
    nf <= nf + int'(sfr === 1'b1);
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic ex);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk(pslverr === ex && (w || prdata === x), "apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Run 1024 samples and count what comes out
  task automatic run(output int a, output int b, output int f);
    a = n0;
    b = n1;
    f = nf;
    en <= 1'b1;
    repeat (2048) @(posedge pclk);
    en <= 1'b0;
    repeat (300) @(posedge pclk);
    a = n0 - a;
    b = n1 - b;
    f = nf - f;
  endtask
  task automatic t_regs();
    apb(0, drcv_pkg::REG_CTRL, 0, 0, 0);
    apb(0, drcv_pkg::REG_DECIM, 0, 32'(drcv_pkg::DECIM_RST), 0);
    apb(0, drcv_pkg::REG_SCALE, 0, 32'(drcv_pkg::SCALE_RST), 0);
    apb(1, drcv_pkg::REG_NCO_FREQ, 32'hA5A50F0F, 0, 0);
    apb(0, drcv_pkg::REG_NCO_FREQ, 0, 32'hA5A50F0F, 0);
    apb(1, drcv_pkg::REG_NCO_PHASE, 32'h80000001, 0, 0);
    apb(0, drcv_pkg::REG_NCO_PHASE, 0, 32'h80000001, 0);
    apb(1, 8'h40, 32'hFFFFFFFF, 0, 1);
    apb(0, 8'h40, 0, 0, 1);
  endtask
  // Serial control frame writes the phase offset; sync master sends its pulse
  task automatic t_pins();
    logic [39:0] f = {drcv_pkg::REG_NCO_PHASE, 32'h1234ABCD};
    ccs_n <= 1'b0;
    for (int i = 39; i >= 0; i--)
    begin
      csdi <= f[i];
      repeat (2) @(posedge pclk);
      csck <= 1'b1;
      repeat (2) @(posedge pclk);
      csck <= 1'b0;
    end
    repeat (2) @(posedge pclk);
    ccs_n <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(0, drcv_pkg::REG_NCO_PHASE, 0, 32'h1234ABCD, 0);
    apb(1, drcv_pkg::REG_CTRL, 32'h00000060, 0, 0);
    repeat (2) @(posedge pclk);
    chk(sno === 1'b1 && snoe === 1'b0, "sync pulse");
  endtask
  // Comb factors 16 and 2, one-tap FIR: one output per 32 samples per channel
  task automatic t_modes();
    int a, b, f;
    int e0[4] = '{32, 16, 16, 32};
    int e1[4] = '{0, 0, 16, 0};
    apb(1, drcv_pkg::REG_DECIM, 32'h0000001F, 0, 0);
    apb(1, drcv_pkg::REG_COEF_ADDR, 0, 0, 0);
    apb(1, drcv_pkg::REG_COEF_DATA, 32'h00040000, 0, 0);
    for (int m = 0; m < 4; m++)
    begin
      apb(1, drcv_pkg::REG_CTRL, 32'(m), 0, 0);
      run(a, b, f);
      chk(a >= e0[m] - 3 && a <= e0[m] + 1, "ch0 rate");
      chk(b >= e1[m] - 3 && b <= e1[m] + 1, "ch1 rate");
    end
  endtask
  // Serial style through the comb bypass, FIR decimating by 32: I and Q frames
  task automatic t_serial();
    int a, b, f;
    sel <= 1'b1;
    apb(1, drcv_pkg::REG_DECIM, 32'h00003E00, 0, 0);
    apb(1, drcv_pkg::REG_CTRL, 32'h00000010, 0, 0);
    run(a, b, f);
    chk(f >= 58 && f <= 66, "frame count");
    sel <= 1'b0;
  endtask
  // Bypass at zero phase after reset: mantissa 4000h gives I 0FFFh and Q zero
  task automatic t_word();
    apb(1, drcv_pkg::REG_CTRL, 32'h00000010, 0, 0);
    en <= 1'b1;
    do @(posedge pclk); while (bb.valid !== 1'b1);
    chk(bb.word === 16'h0FFF && bb.iq === 1'b0 && bb.ch === 1'b0, "I word");
    @(posedge pclk);
    chk(bb.word === 16'h0000 && bb.iq === 1'b1 && bb.valid === 1'b1, "Q word");
    en <= 1'b0;
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pins();
    t_modes();
    t_serial();
    // Second reset mid-run returns the defaults
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, drcv_pkg::REG_DECIM, 0, 32'(drcv_pkg::DECIM_RST), 0);
    t_word();
    wrap_up();
  end
endmodule
`default_nettype wire
